// File: gpr_top.sv
// General-purpose I/O port pair: sixteen pins, APB register file, edge interrupts.
// Assumes an APB master on CLK_SYS and pin inputs already synchronous to CLK_SYS.
//
// Functional notes
// - First port vector: zero, else 2*index+2.
// - Second port vector uses the same encoding.
// - Edge select zero rising, one falling.
// - Enable one permits request; resets to zero.
// - Flags readable, writable, reset to zero.
// - Input register shows pin levels; writes ignored.
// - Output pin driven by its output bit.
// - Input pull: output bit picks up/down.
// - Direction zero input, one output; reset input.
// - Drive bit zero reduced drive; resets zero.
// - Drive bit one gives full drive.
// - Pair registers take word and byte access.
`timescale 1ns/10ps
module gpr_top (
    input wire logic CLK_SYS, // System clock, 25 MHz.
    input wire logic RST_B, // Asynchronous reset, active low.
    input wire logic PSEL, // APB select.
    input wire logic PENABLE, // APB enable.
    input wire logic PWRITE, // APB direction, high for write.
    input wire logic [7:0] PADDR, // APB byte address.
    input wire logic [31:0] PWDATA, // APB write data.
    input wire logic [3:0] PSTRB, // APB write byte strobes.
    output logic [31:0] PRDATA, // APB read data.
    output logic PREADY, // APB ready.
    output logic PSLVERR, // APB error for unmapped addresses.
    input wire logic [15:0] PIN_IN, // Pin levels.
    output logic [15:0] PIN_OUT, // Pin output levels.
    output logic [15:0] PIN_OE, // Pin output enables.
    output logic [15:0] PIN_PULL_EN, // Pull resistor connect.
    output logic [15:0] PIN_PULL_UP, // Pull direction, high for pullup.
    output logic [15:0] PIN_FULL_DRIVE, // Full drive strength.
    output logic [15:0] PIN_FUNC_SEL, // Function select.
    output logic [15:0] IRQ_REQ, // Per-pin interrupt requests.
    output logic IRQ // Summary interrupt, level.
);

    logic [15:0] pin_in_ff, pin_prev_ff, nxt_pin_in, nxt_pin_prev;
    logic [15:0] out_ff, dir_ff, ren_ff, ds_ff, sel_ff, ies_ff, ie_ff, stat_ff, mask_ff;
    logic [15:0] nxt_out, nxt_dir, nxt_ren, nxt_ds, nxt_sel, nxt_ies, nxt_ie, nxt_stat, nxt_mask;
    logic [15:0] stat_clr, flag_w, event_w, vec1_w, vec2_w, rd_word;
    logic [15:0] irq_req_ff, nxt_irq_req;
    logic irq_ff, nxt_irq;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic [5:0] idx, base;
    logic odd, setup, access, mapped, do_wr, wr_lo, wr_hi;
    logic [7:0] dat_lo, dat_hi;

    // Byte-lane merge for a sixteen-bit register hit by the current write.
    function automatic logic [15:0] merge(input logic [15:0] old, input logic hit, input logic lo,
                                          input logic hi, input logic [7:0] dl, input logic [7:0] dh);
        logic [15:0] v;
        v = old;
        if (hit && lo) begin
            v[7:0] = dl;
        end
        if (hit && hi) begin
            v[15:8] = dh;
        end
        return v;
    endfunction

    // Address decode. An odd index reaches the high byte through the low data lane.
    always_comb begin
        idx = PADDR[7:2];
        base = {idx[5:1], 1'b0};
        odd = idx[0];
        setup = PSEL & ~PENABLE;
        access = PSEL & PENABLE & pready_ff;
        case (base)
            gpr_pkg::GPR_IDX_IN, gpr_pkg::GPR_IDX_OUT, gpr_pkg::GPR_IDX_DIR, gpr_pkg::GPR_IDX_REN,
            gpr_pkg::GPR_IDX_DS, gpr_pkg::GPR_IDX_SEL, gpr_pkg::GPR_IDX_VEC1, gpr_pkg::GPR_IDX_IES,
            gpr_pkg::GPR_IDX_IE, gpr_pkg::GPR_IDX_IFG, gpr_pkg::GPR_IDX_VEC2, gpr_pkg::GPR_IDX_STAT,
            gpr_pkg::GPR_IDX_MASK: begin
                mapped = (PADDR[1:0] == gpr_pkg::GPR_ADDR_ALIGN);
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        do_wr = access & PWRITE & mapped;
        wr_lo = do_wr & ~odd & PSTRB[0];
        wr_hi = do_wr & (odd ? PSTRB[0] : PSTRB[1]);
        dat_lo = PWDATA[7:0];
        dat_hi = odd ? PWDATA[7:0] : PWDATA[15:8];
    end

    // Configuration register next values. Writes to the input and vector registers fall on nothing.
    always_comb begin
        nxt_out = merge(out_ff, base == gpr_pkg::GPR_IDX_OUT, wr_lo, wr_hi, dat_lo, dat_hi);
        nxt_dir = merge(dir_ff, base == gpr_pkg::GPR_IDX_DIR, wr_lo, wr_hi, dat_lo, dat_hi);
        nxt_ren = merge(ren_ff, base == gpr_pkg::GPR_IDX_REN, wr_lo, wr_hi, dat_lo, dat_hi);
        nxt_ds = merge(ds_ff, base == gpr_pkg::GPR_IDX_DS, wr_lo, wr_hi, dat_lo, dat_hi);
        nxt_sel = merge(sel_ff, base == gpr_pkg::GPR_IDX_SEL, wr_lo, wr_hi, dat_lo, dat_hi);
        nxt_ies = merge(ies_ff, base == gpr_pkg::GPR_IDX_IES, wr_lo, wr_hi, dat_lo, dat_hi);
        nxt_ie = merge(ie_ff, base == gpr_pkg::GPR_IDX_IE, wr_lo, wr_hi, dat_lo, dat_hi);
        nxt_mask = merge(mask_ff, base == gpr_pkg::GPR_IDX_MASK, wr_lo, wr_hi, dat_lo, dat_hi);
        // Status is write-one-to-clear; a new edge in the same cycle keeps its bit set.
        stat_clr = merge(gpr_pkg::GPR_RST_PAIR, base == gpr_pkg::GPR_IDX_STAT, wr_lo, wr_hi, dat_lo, dat_hi);
        nxt_stat = (stat_ff & ~stat_clr) | event_w;
    end

    // Configuration registers; all come out of reset at zero, so every pin starts as an input.
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            out_ff <= gpr_pkg::GPR_RST_PAIR;
            dir_ff <= gpr_pkg::GPR_RST_PAIR;
            ren_ff <= gpr_pkg::GPR_RST_PAIR;
            ds_ff <= gpr_pkg::GPR_RST_PAIR;
            sel_ff <= gpr_pkg::GPR_RST_PAIR;
            ies_ff <= gpr_pkg::GPR_RST_PAIR;
            ie_ff <= gpr_pkg::GPR_RST_PAIR;
            stat_ff <= gpr_pkg::GPR_RST_PAIR;
            mask_ff <= gpr_pkg::GPR_RST_PAIR;
        end else begin
            out_ff <= nxt_out;
            dir_ff <= nxt_dir;
            ren_ff <= nxt_ren;
            ds_ff <= nxt_ds;
            sel_ff <= nxt_sel;
            ies_ff <= nxt_ies;
            ie_ff <= nxt_ie;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
        end
    end

    // Port one sits in the low byte of the pair, port two in the high byte.
    gpr_port_irq u_port1 (
        .clk_sys(CLK_SYS),
        .rst_b(RST_B),
        .pin_now(pin_in_ff[7:0]),
        .pin_prev(pin_prev_ff[7:0]),
        .edge_sel(ies_ff[7:0]),
        .flag_wr(wr_lo && base == gpr_pkg::GPR_IDX_IFG),
        .flag_wdata(dat_lo),
        .flag_ff(flag_w[7:0]),
        .pin_event(event_w[7:0]),
        .vector_ff(vec1_w)
    );

    gpr_port_irq u_port2 (
        .clk_sys(CLK_SYS),
        .rst_b(RST_B),
        .pin_now(pin_in_ff[15:8]),
        .pin_prev(pin_prev_ff[15:8]),
        .edge_sel(ies_ff[15:8]),
        .flag_wr(wr_hi && base == gpr_pkg::GPR_IDX_IFG),
        .flag_wdata(dat_hi),
        .flag_ff(flag_w[15:8]),
        .pin_event(event_w[15:8]),
        .vector_ff(vec2_w)
    );

    gpr_pad_ctl u_pad (
        .clk_sys(CLK_SYS),
        .rst_b(RST_B),
        .out_val(out_ff),
        .dir(dir_ff),
        .pull_en(ren_ff),
        .drive(ds_ff),
        .func_sel(sel_ff),
        .pin_out_ff(PIN_OUT),
        .pin_oe_ff(PIN_OE),
        .pull_en_ff(PIN_PULL_EN),
        .pull_up_ff(PIN_PULL_UP),
        .full_drive_ff(PIN_FULL_DRIVE),
        .func_sel_ff(PIN_FUNC_SEL)
    );

    // Read mux; data is captured in the setup cycle so the answer leaves a flip-flop.
    always_comb begin
        case (base)
            gpr_pkg::GPR_IDX_IN: rd_word = pin_in_ff;
            gpr_pkg::GPR_IDX_OUT: rd_word = out_ff;
            gpr_pkg::GPR_IDX_DIR: rd_word = dir_ff;
            gpr_pkg::GPR_IDX_REN: rd_word = ren_ff;
            gpr_pkg::GPR_IDX_DS: rd_word = ds_ff;
            gpr_pkg::GPR_IDX_SEL: rd_word = sel_ff;
            gpr_pkg::GPR_IDX_VEC1: rd_word = vec1_w;
            gpr_pkg::GPR_IDX_IES: rd_word = ies_ff;
            gpr_pkg::GPR_IDX_IE: rd_word = ie_ff;
            gpr_pkg::GPR_IDX_IFG: rd_word = flag_w;
            gpr_pkg::GPR_IDX_VEC2: rd_word = vec2_w;
            gpr_pkg::GPR_IDX_STAT: rd_word = stat_ff;
            gpr_pkg::GPR_IDX_MASK: rd_word = mask_ff;
            default: rd_word = gpr_pkg::GPR_RST_PAIR;
        endcase
        nxt_prdata = gpr_pkg::GPR_RST_RDATA;
        if (setup && !PWRITE && mapped) begin
            nxt_prdata = odd ? {24'h00_0000, rd_word[15:8]} : {16'h0000, rd_word};
        end
        nxt_pready = setup;
        nxt_pslverr = setup & ~mapped;
    end

    // Bus answer registers: every transfer completes in its first access cycle.
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            prdata_ff <= gpr_pkg::GPR_RST_RDATA;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Pin sampling and interrupt outputs. Inputs are already synchronous, so one stage suffices.
    always_comb begin
        nxt_pin_in = PIN_IN;
        nxt_pin_prev = pin_in_ff;
        nxt_irq_req = flag_w & ie_ff;
        nxt_irq = |(stat_ff & mask_ff);
    end

    // Pin sample and interrupt registers.
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            pin_in_ff <= gpr_pkg::GPR_RST_PAIR;
            pin_prev_ff <= gpr_pkg::GPR_RST_PAIR;
            irq_req_ff <= gpr_pkg::GPR_RST_PAIR;
            irq_ff <= 1'b0;
        end else begin
            pin_in_ff <= nxt_pin_in;
            pin_prev_ff <= nxt_pin_prev;
            irq_req_ff <= nxt_irq_req;
            irq_ff <= nxt_irq;
        end
    end

    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign IRQ_REQ = irq_req_ff;
    assign IRQ = irq_ff;

    property p_in_read;
        @(posedge CLK_SYS) disable iff (!RST_B)
            (setup && !PWRITE && PADDR == 8'h00) |=> (PRDATA == {16'h0000, $past(pin_in_ff)});
    endproperty
    a_in_read: assert property (p_in_read) else $error("Input read does not show pin levels.");

    property p_in_write;
        @(posedge CLK_SYS) disable iff (!RST_B)
            (access && PWRITE && PADDR == 8'h00) |=> (pin_in_ff == $past(PIN_IN) && out_ff == $past(out_ff));
    endproperty
    a_in_write: assert property (p_in_write) else $error("Input register changed by a write.");

    property p_ie_block;
        @(posedge CLK_SYS) disable iff (!RST_B) !ie_ff[0] |=> !IRQ_REQ[0];
    endproperty
    a_ie_block: assert property (p_ie_block) else $error("Disabled pin raised a request.");

    property p_req;
        @(posedge CLK_SYS) disable iff (!RST_B) (flag_w[8] && ie_ff[8]) |=> IRQ_REQ[8];
    endproperty
    a_req: assert property (p_req) else $error("Enabled flag raised no request.");

    property p_byte_hi;
        @(posedge CLK_SYS) disable iff (!RST_B)
            (access && PWRITE && PADDR == 8'h0C && PSTRB[0]) |=> (out_ff[15:8] == $past(PWDATA[7:0]));
    endproperty
    a_byte_hi: assert property (p_byte_hi) else $error("High byte write missed.");

    property p_word;
        @(posedge CLK_SYS) disable iff (!RST_B)
            (access && PWRITE && PADDR == 8'h10 && PSTRB[1:0] == 2'h3) |=> ##1 (PIN_OE == $past(PWDATA[15:0], 2));
    endproperty
    a_word: assert property (p_word) else $error("Word write did not reach the pin enables.");

    property p_full;
        @(posedge CLK_SYS) disable iff (!RST_B) ds_ff[5] |=> PIN_FULL_DRIVE[5];
    endproperty
    a_full: assert property (p_full) else $error("Full drive not selected.");

    // Ready must drop after one cycle; a held ready would let the master complete a phantom access.
    property p_ready_pulse;
        @(posedge CLK_SYS) disable iff (!RST_B) PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held for more than one cycle.");

    property p_err_zero;
        @(posedge CLK_SYS) disable iff (!RST_B) PSLVERR |-> (PREADY && PRDATA == 32'h0000_0000);
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("Error answer without ready or with data.");

    property p_stat_set;
        @(posedge CLK_SYS) disable iff (!RST_B) event_w[8] |=> stat_ff[8];
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("Selected edge did not set its status bit.");

    property p_irq_level;
        @(posedge CLK_SYS) disable iff (!RST_B) (stat_ff[0] && mask_ff[0]) |=> IRQ;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Unmasked status bit raised no interrupt.");

    c_irq: cover property (@(posedge CLK_SYS) disable iff (!RST_B) IRQ);
    c_err: cover property (@(posedge CLK_SYS) disable iff (!RST_B) PSLVERR && PREADY);
    c_vec2: cover property (@(posedge CLK_SYS) disable iff (!RST_B) access && !PWRITE && PADDR == 8'h78);

endmodule

// File: gpr_pkg.sv
// Shared constants for the general-purpose I/O port pair block.
// Assumes an APB slave with 32-bit data; each register's byte address is four times its index.
package gpr_pkg;

    // Pin counts: one port is eight pins, the pair is sixteen.
    localparam int GPR_PORT_W = 8;
    localparam int GPR_PAIR_W = 16;

    // Register indices; the APB byte address is four times the index, odd indices reach the high byte.
    localparam logic [5:0] GPR_IDX_IN = 6'h00;
    localparam logic [5:0] GPR_IDX_OUT = 6'h02;
    localparam logic [5:0] GPR_IDX_DIR = 6'h04;
    localparam logic [5:0] GPR_IDX_REN = 6'h06;
    localparam logic [5:0] GPR_IDX_DS = 6'h08;
    localparam logic [5:0] GPR_IDX_SEL = 6'h0A;
    localparam logic [5:0] GPR_IDX_VEC1 = 6'h0E;
    localparam logic [5:0] GPR_IDX_IES = 6'h18;
    localparam logic [5:0] GPR_IDX_IE = 6'h1A;
    localparam logic [5:0] GPR_IDX_IFG = 6'h1C;
    localparam logic [5:0] GPR_IDX_VEC2 = 6'h1E;
    localparam logic [5:0] GPR_IDX_STAT = 6'h20;
    localparam logic [5:0] GPR_IDX_MASK = 6'h22;

    // Reset values.
    localparam logic [15:0] GPR_RST_PAIR = 16'h0000;
    localparam logic [7:0] GPR_RST_PORT = 8'h00;
    localparam logic [15:0] GPR_RST_VEC = 16'h0000;
    localparam logic [31:0] GPR_RST_RDATA = 32'h0000_0000;

    // Vector encoding: pin i of a port reads as GPR_VEC_STEP times (i + 1).
    localparam logic [4:0] GPR_VEC_STEP = 5'h02;

    // Only word-aligned byte addresses are mapped.
    localparam logic [1:0] GPR_ADDR_ALIGN = 2'h0;

endpackage

// File: gpr_port_irq.sv
// Edge detection, interrupt flags and priority vector for one eight-pin port.
// Assumes pin_now and pin_prev are consecutive registered samples of the pins.
`timescale 1ns/10ps
module gpr_port_irq (
    input wire logic clk_sys, // System clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic [gpr_pkg::GPR_PORT_W-1:0] pin_now, // Current pin sample.
    input wire logic [gpr_pkg::GPR_PORT_W-1:0] pin_prev, // Previous pin sample.
    input wire logic [gpr_pkg::GPR_PORT_W-1:0] edge_sel, // Zero rising, one falling.
    input wire logic flag_wr, // Software write strobe for the flags.
    input wire logic [gpr_pkg::GPR_PORT_W-1:0] flag_wdata, // Software write data.
    output logic [gpr_pkg::GPR_PORT_W-1:0] flag_ff, // Pending flags.
    output logic [gpr_pkg::GPR_PORT_W-1:0] pin_event, // Selected edge seen this cycle.
    output logic [15:0] vector_ff // Priority vector of the pending flags.
);

    logic [gpr_pkg::GPR_PORT_W-1:0] nxt_flag;
    logic [15:0] nxt_vector;

    // Lowest pending index wins, so the loop runs downward and the last hit stands.
    function automatic logic [15:0] encode(input logic [gpr_pkg::GPR_PORT_W-1:0] f);
        logic [15:0] v;
        v = gpr_pkg::GPR_RST_VEC;
        for (int i = gpr_pkg::GPR_PORT_W - 1; i >= 0; i--) begin
            if (f[i]) begin
                v = 16'(gpr_pkg::GPR_VEC_STEP * (i + 1));
            end
        end
        return v;
    endfunction

    // An edge landing in the same cycle as a software write still sets its flag.
    always_comb begin
        pin_event = (~edge_sel & pin_now & ~pin_prev) | (edge_sel & ~pin_now & pin_prev);
        nxt_flag = (flag_wr ? flag_wdata : flag_ff) | pin_event;
        nxt_vector = encode(flag_ff);
    end

    // Flags and vector registers.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flag_ff <= gpr_pkg::GPR_RST_PORT;
            vector_ff <= gpr_pkg::GPR_RST_VEC;
        end else begin
            flag_ff <= nxt_flag;
            vector_ff <= nxt_vector;
        end
    end

    property p_vec_none;
        @(posedge clk_sys) disable iff (!rst_b) (flag_ff == 8'h00) |=> (vector_ff == 16'h0000);
    endproperty
    a_vec_none: assert property (p_vec_none) else $error("Vector not zero with no flag pending.");

    property p_vec_prio;
        @(posedge clk_sys) disable iff (!rst_b) flag_ff[0] |=> (vector_ff == 16'h0002);
    endproperty
    a_vec_prio: assert property (p_vec_prio) else $error("Bit zero did not win the vector.");

    property p_vec_low;
        @(posedge clk_sys) disable iff (!rst_b) (flag_ff == 8'h80) |=> (vector_ff == 16'h0010);
    endproperty
    a_vec_low: assert property (p_vec_low) else $error("Bit seven vector is wrong.");

    property p_rise;
        @(posedge clk_sys) disable iff (!rst_b) (!edge_sel[0] && pin_now[0] && !pin_prev[0]) |=> flag_ff[0];
    endproperty
    a_rise: assert property (p_rise) else $error("Rising edge did not set the flag.");

    property p_fall;
        @(posedge clk_sys) disable iff (!rst_b) (edge_sel[7] && !pin_now[7] && pin_prev[7]) |=> flag_ff[7];
    endproperty
    a_fall: assert property (p_fall) else $error("Falling edge did not set the flag.");

    property p_set_wins;
        @(posedge clk_sys) disable iff (!rst_b) (flag_wr && !flag_wdata[3] && pin_event[3]) |=> flag_ff[3];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Edge lost against a flag clear.");

    c_vec_mid: cover property (@(posedge clk_sys) disable iff (!rst_b) vector_ff == 16'h0008);

endmodule

// File: gpr_pad_ctl.sv
// Registered pad controls derived from the pin configuration registers.
// Assumes the pad cell resolves output, enable, pull and drive strength itself.
`timescale 1ns/10ps
module gpr_pad_ctl (
    input wire logic clk_sys, // System clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic [15:0] out_val, // Output level or pull direction.
    input wire logic [15:0] dir, // Zero input, one output.
    input wire logic [15:0] pull_en, // Pull resistor enable.
    input wire logic [15:0] drive, // Zero reduced, one full drive.
    input wire logic [15:0] func_sel, // Function select.
    output logic [15:0] pin_out_ff, // Pad output level.
    output logic [15:0] pin_oe_ff, // Pad output enable, high while driving.
    output logic [15:0] pull_en_ff, // Pull resistor connected.
    output logic [15:0] pull_up_ff, // Pull toward high when connected.
    output logic [15:0] full_drive_ff, // Full output drive.
    output logic [15:0] func_sel_ff // Function select to the pad mux.
);

    logic [15:0] nxt_out, nxt_oe, nxt_pen, nxt_pup, nxt_full;

    // Pulls only act on inputs; a driven pin never fights its own resistor.
    always_comb begin
        nxt_oe = dir;
        nxt_out = out_val;
        nxt_pen = pull_en & ~dir;
        nxt_pup = pull_en & ~dir & out_val;
        nxt_full = drive;
    end

    // Pad control registers.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_out_ff <= gpr_pkg::GPR_RST_PAIR;
            pin_oe_ff <= gpr_pkg::GPR_RST_PAIR;
            pull_en_ff <= gpr_pkg::GPR_RST_PAIR;
            pull_up_ff <= gpr_pkg::GPR_RST_PAIR;
            full_drive_ff <= gpr_pkg::GPR_RST_PAIR;
            func_sel_ff <= gpr_pkg::GPR_RST_PAIR;
        end else begin
            pin_out_ff <= nxt_out;
            pin_oe_ff <= nxt_oe;
            pull_en_ff <= nxt_pen;
            pull_up_ff <= nxt_pup;
            full_drive_ff <= nxt_full;
            func_sel_ff <= func_sel;
        end
    end

    property p_drive_out;
        @(posedge clk_sys) disable iff (!rst_b) (dir[0] && out_val[0]) |=> (pin_oe_ff[0] && pin_out_ff[0]);
    endproperty
    a_drive_out: assert property (p_drive_out) else $error("Output pin not driven high.");

    property p_pull_down;
        @(posedge clk_sys) disable iff (!rst_b) (!dir[1] && pull_en[1] && !out_val[1]) |=> (pull_en_ff[1] && !pull_up_ff[1]);
    endproperty
    a_pull_down: assert property (p_pull_down) else $error("Pulldown not selected.");

    property p_no_pull;
        @(posedge clk_sys) disable iff (!rst_b) (!pull_en[2] || dir[2]) |=> !pull_en_ff[2];
    endproperty
    a_no_pull: assert property (p_no_pull) else $error("Pull resistor connected wrongly.");

    property p_input;
        @(posedge clk_sys) disable iff (!rst_b) !dir[4] |=> !pin_oe_ff[4];
    endproperty
    a_input: assert property (p_input) else $error("Input pin is being driven.");

    property p_drive;
        @(posedge clk_sys) disable iff (!rst_b) ##1 (full_drive_ff[3] == $past(drive[3]));
    endproperty
    a_drive: assert property (p_drive) else $error("Drive strength does not follow its bit.");

endmodule

// File: gpr_board.sv
// Board model for the port pair: resolves every pin from the pad controls and an external source.
// Assumes the bench owns the external source and the design owns the pad controls.
`timescale 1ns/10ps
module gpr_board (
    input wire logic clk_sys, // System clock.
    input wire logic [15:0] pin_out, // Pad output level.
    input wire logic [15:0] pin_oe, // Pad output enable.
    input wire logic [15:0] pull_en, // Pull resistor connected.
    input wire logic [15:0] pull_up, // Pull toward high.
    input wire logic [15:0] ext_val, // External level.
    input wire logic [15:0] ext_drv, // External source active.
    output logic [15:0] pin_lvl // Resolved pin level.
);
    logic [15:0] last_ff = 16'h0000;
    logic [15:0] held;
    assign held = pin_oe | ext_drv | pull_en;
    // A floating pin shows the inverse of its last level, so a stale value never passes for a real one.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (pin_oe[i]) pin_lvl[i] = pin_out[i];
            else if (ext_drv[i]) pin_lvl[i] = ext_val[i];
            else if (pull_en[i]) pin_lvl[i] = pull_up[i];
            else pin_lvl[i] = ~last_ff[i];
        end
    end
    // Last driven level of each pin; a released pin holds its inverse steadily instead of toggling.
    always @(posedge clk_sys) last_ff <= (pin_lvl & held) | (last_ff & ~held);
endmodule

// File: tb.sv
// Self-checking bench for the port pair: APB master, board model and interrupt traffic.
// Assumes the design answers reads in the access cycle; expected reads wait in a queue.
`timescale 1ns/10ps
module tb;
    logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, irq;
    logic [15:0] pin_in, pin_out, pin_oe, pen, pup, pfd, pfs, irq_req;
    logic [15:0] ext_val = 16'h0000, ext_drv = 16'hFFFF, lf = 16'hC9B4;
    logic [32:0] exp_q[$];
    logic [5:0] ix [7] = '{gpr_pkg::GPR_IDX_DIR, gpr_pkg::GPR_IDX_REN, gpr_pkg::GPR_IDX_DS, gpr_pkg::GPR_IDX_SEL,
        gpr_pkg::GPR_IDX_IE, gpr_pkg::GPR_IDX_IFG, gpr_pkg::GPR_IDX_VEC1};
    int num_errors = 0, samples_checked = 0;
    // Clock of 40 ns period.
    always #20 clk_sys = ~clk_sys;
    gpr_top gpr_top_i (.CLK_SYS(clk_sys), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULL_EN(pen), .PIN_PULL_UP(pup),
        .PIN_FULL_DRIVE(pfd), .PIN_FUNC_SEL(pfs), .IRQ_REQ(irq_req), .IRQ(irq));
    gpr_board gpr_board_i (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pen),
        .pull_up(pup), .ext_val(ext_val), .ext_drv(ext_drv), .pin_lvl(pin_in));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One transfer; an idle edge comes first so no signal is assigned twice in one step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
        input logic [32:0] e);
        @(posedge clk_sys);
        if (!wr) exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] x, input logic [15:0] e);
        apb(1'b0, {x, 2'b00}, 16'h0000, 4'h0, {17'h0, e});
    endtask
    task automatic wr(input logic [5:0] x, input logic [15:0] d);
        apb(1'b1, {x, 2'b00}, d, 4'h3, 33'h0);
    endtask
    // Read monitor: the oldest note is compared with each completed read.
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("[ERR] t=%0t got=%h exp=none", $time, {pslverr, prdata});
            end else chk({pslverr, prdata}, exp_q.pop_front());
        end
    end
    // Main sequence.
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (ix[i]) rd(ix[i], 16'h0000);
        lf = lfsr(lf);
        wr(gpr_pkg::GPR_IDX_OUT, lf);
        apb(1'b1, {gpr_pkg::GPR_IDX_OUT + 6'h01, 2'b00}, 16'h005A, 4'h1, 33'h0);
        rd(gpr_pkg::GPR_IDX_OUT, {8'h5A, lf[7:0]});
        rd(gpr_pkg::GPR_IDX_OUT + 6'h01, 16'h005A);
        wr(gpr_pkg::GPR_IDX_DIR, 16'h00FF);
        wr(gpr_pkg::GPR_IDX_REN, 16'hFF00);
        wr(gpr_pkg::GPR_IDX_DS, 16'h00F0);
        wr(gpr_pkg::GPR_IDX_SEL, 16'h8001);
        ext_val <= lfsr(lf);
        ext_drv <= 16'h0F00;
        wr(gpr_pkg::GPR_IDX_IN, 16'hFFFF);
        rd(gpr_pkg::GPR_IDX_IN, {4'h5, ext_val[11:8], lf[7:0]});
        chk({1'b0, pen, pup}, {1'b0, 16'hFF00, 16'h5A00});
        chk({1'b0, pin_oe, pfd}, {1'b0, 16'h00FF, 16'h00F0});
        chk({17'h0, pfs}, {17'h0, 16'h8001});
        apb(1'b0, 8'h40, 16'h0000, 4'h0, {1'b1, 32'h0});
        // Interrupt traffic: all pins inputs driven by the board.
        wr(gpr_pkg::GPR_IDX_DIR, 16'h0000);
        ext_drv <= 16'hFFFF;
        ext_val <= 16'h0000;
        wr(gpr_pkg::GPR_IDX_IES, 16'hFF00);
        wr(gpr_pkg::GPR_IDX_IFG, 16'h0000);
        ext_val <= 16'hFF00;
        repeat (4) @(posedge clk_sys);
        rd(gpr_pkg::GPR_IDX_IFG, 16'h0000);
        for (int i = 7; i >= 0; i--) begin
            ext_val <= ext_val ^ (16'h0101 << i);
            repeat (4) @(posedge clk_sys);
            rd(gpr_pkg::GPR_IDX_VEC1, 16'(2 * i + 2));
            rd(gpr_pkg::GPR_IDX_VEC2, 16'(2 * i + 2));
        end
        chk({32'h0, irq}, 33'h0);
        wr(gpr_pkg::GPR_IDX_IE, 16'h0101);
        wr(gpr_pkg::GPR_IDX_MASK, 16'h0001);
        repeat (3) @(posedge clk_sys);
        chk({16'h0, irq_req, irq}, {16'h0, 16'h0101, 1'b1});
        wr(gpr_pkg::GPR_IDX_STAT, 16'hFFFF);
        wr(gpr_pkg::GPR_IDX_IFG, 16'h00FE);
        repeat (3) @(posedge clk_sys);
        chk({16'h0, irq_req, irq}, 33'h0);
        rd(gpr_pkg::GPR_IDX_IFG, 16'h00FE);
        rd(gpr_pkg::GPR_IDX_VEC1, 16'h0004);
        rd(gpr_pkg::GPR_IDX_VEC2, 16'h0000);
        repeat (3) @(posedge clk_sys);
        wrap_up();
    end
    // Watchdog well past the fewer than two hundred cycles the sequence needs.
    initial begin
        #(40 * 4000);
        num_errors++;
        wrap_up();
    end
endmodule
